// ### rtl/auxseq_pkg.sv
package auxseq_pkg;

	// ---------------------------------------------------------------
	// Run modes and slots
	// ---------------------------------------------------------------
	localparam logic [1:0] MODE_STOP   = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_CONT   = 2'h2;
	localparam logic [1:0] MODE_EIGHT  = 2'h3;

	localparam int          GPIO_COUNT   = 8;
	localparam int          MISC_COUNT   = 12;
	localparam logic [3:0]  MISC_LAST    = 4'hb;
	localparam logic [2:0]  GPIO_LAST    = 3'h7;
	localparam logic [3:0]  RR_EIGHT     = 4'h8;
	localparam logic [15:0] RESULT_RESET = 16'h8000;

	// Slot of the cell multiplexer inside the cycle; main ADC fixed slot.
	localparam logic [3:0] CELL_SLOT      = 4'h5;
	localparam logic [3:0] MAIN_FIXED_SLOT = 4'hc;

	// GPIO pin functions that route the pin to the converter.
	localparam logic [2:0] PIN_ADC       = 3'h2;
	localparam logic [2:0] PIN_ADC_PROT  = 3'h3;

	// Cell select: 0 loops, 1..16 lock a cell, 17 locks the bus-bar.
	localparam logic [4:0] CELL_SEL_LOOP = 5'h00;
	localparam logic [4:0] CELL_SEL_BB   = 5'h11;
	localparam logic [4:0] BB_CHANNEL    = 5'h11;
	// GPIO select: 0 loops, 1..8 lock that GPIO.
	localparam logic [3:0] GPIO_SEL_LOOP = 4'h0;

	// ---------------------------------------------------------------
	// Settling times
	// ---------------------------------------------------------------
	localparam int CLK_MHZ       = 200;
	localparam int SETTLE_A_US   = 4300;
	localparam int SETTLE_B_US   = 2300;
	localparam int SETTLE_C_US   = 1300;
	localparam int SETTLE_A_CYC  = SETTLE_A_US * CLK_MHZ;
	localparam int SETTLE_B_CYC  = SETTLE_B_US * CLK_MHZ;
	localparam int SETTLE_C_CYC  = SETTLE_C_US * CLK_MHZ;
	localparam logic [1:0] SETTLE_SEL_RESET = 2'h0;

	typedef enum logic [1:0] {
		AUXSEQ_IDLE,
		AUXSEQ_RUN,
		AUXSEQ_FROZEN
	} auxseq_state_t;

endpackage

// ### rtl/auxseq_settle.sv
`timescale 1ns/10ps
// Counts the settling wait after the cell multiplexer moves.
module auxseq_settle (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Control
	input  wire logic        restart_in,
	input  wire logic        tick_in,
	input  wire logic [1:0]  select_in,
	input  wire logic [31:0] limit_a_in,
	input  wire logic [31:0] limit_b_in,
	input  wire logic [31:0] limit_c_in,
	// Status
	output logic             settled_out
);

	logic [31:0] count_reg;
	logic [31:0] limit;

	always_comb begin
		unique case (select_in)
			2'h1:    limit = limit_b_in;
			2'h2:    limit = limit_c_in;
			default: limit = limit_a_in;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_reg <= 32'h0;
		end else if (restart_in) begin
			count_reg <= 32'h0;
		end else if (tick_in && count_reg < limit) begin
			count_reg <= count_reg + 32'h1;
		end
	end

	assign settled_out = (count_reg >= limit);

endmodule // auxseq_settle

// ### rtl/auxseq_slot.sv
`timescale 1ns/10ps
// Slot counter of one round-robin cycle: cell slot plus twelve misc
// inputs plus one GPIO slot. The cell slot position moves with the
// main converter when alignment is dynamic.
module auxseq_slot (
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	// Control
	input  wire logic       step_in,
	input  wire logic       clear_in,
	input  wire logic [3:0] cell_pos_in,
	// Slot state
	output logic [3:0]      slot_out,
	output logic            cell_slot_out,
	output logic            gpio_slot_out,
	output logic            cycle_end_out
);

	localparam logic [3:0] LAST_SLOT = 4'hd;

	logic [3:0] slot_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_reg <= 4'h0;
		end else if (clear_in) begin
			slot_reg <= 4'h0;
		end else if (step_in) begin
			slot_reg <= (slot_reg == LAST_SLOT) ? 4'h0 : slot_reg + 4'h1;
		end
	end

	assign slot_out      = slot_reg;
	assign cell_slot_out = (slot_reg == cell_pos_in);
	assign gpio_slot_out = (slot_reg == LAST_SLOT);
	assign cycle_end_out = step_in && (slot_reg == LAST_SLOT);

endmodule // auxseq_slot

// ### rtl/auxseq_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// - One GPIO slot per round-robin cycle.
// - First cycle measures GPIO1, then steps onward.
// - Looping measures every GPIO; ADC configuration gates only the locked result.
// - Looping GPIO select writes no result.
// - Locked GPIO reports result, otherwise 0x8000.
// - All twelve misc inputs converted every cycle.
// - Protector DAC inputs show live thresholds.
// - Go starts converter and latches configuration.
// - Run status high while converter runs.
// - Misc ready after all misc converted.
// - Cell ready after selected channels converted.
// - GPIO ready after all eight GPIO channels visited.
// - Continuous mode runs until stop go.
// - Single mode runs one cycle.
// - Eight mode runs eight cycles then stops.
// - Sleep freezes state; wake resumes it.
// - Dynamic alignment moves cell slot to main.
// - Fixed alignment ties cell slot to slot 5 (meets main slot 12).
// - Three settling waits; wait conversions discarded.
// - Cell slot visits only active cells and bus-bar, or the selected one.
// - Locked active channel updates cell result after settle.
module auxseq_top (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	// Command and configuration
	input  wire logic        aux_go_in,
	input  wire logic [1:0]  aux_run_mode_in,
	input  wire logic [4:0]  aux_cell_select_in,
	input  wire logic [1:0]  aux_settle_select_in,
	input  wire logic [3:0]  aux_gpio_select_in,
	input  wire logic [3:0]  active_cell_count_in,
	input  wire logic [23:0] pin_function_config_in,
	input  wire logic        cell_align_fixed_in,
	// Power mode and main converter
	input  wire logic        active_mode_in,
	input  wire logic [3:0]  main_cell_slot_in,
	// Converter
	input  wire logic        conv_done_in,
	input  wire logic [15:0] conv_data_in,
	// Live protector thresholds
	input  wire logic [15:0] prot_dac_in,
	// Converter steering
	output logic [3:0]       slot_out,
	output logic [4:0]       cell_channel_out,
	output logic [2:0]       gpio_channel_out,
	output logic             conv_enable_out,
	// Status
	output logic             aux_run_out,
	output logic             misc_ready_flag_out,
	output logic             cell_ready_flag_out,
	output logic             gpio_ready_flag_out,
	// Results
	output logic [7:0]       gpio_result_high_out,
	output logic [7:0]       gpio_result_low_out,
	output logic [15:0]      cell_result_out,
	output logic [15:0]      misc_result_out,
	output logic [3:0]       misc_index_out,
	output logic             misc_valid_out
);

	// ---------------------------------------------------------------
	// Latched configuration
	// ---------------------------------------------------------------
	logic [1:0]  mode_reg;
	logic [4:0]  cell_sel_reg;
	logic [1:0]  settle_sel_reg;
	logic [3:0]  gpio_sel_reg;
	logic [3:0]  cell_count_reg;
	logic [23:0] pin_cfg_reg;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_reg       <= auxseq_pkg::MODE_STOP;
			cell_sel_reg   <= auxseq_pkg::CELL_SEL_LOOP;
			settle_sel_reg <= auxseq_pkg::SETTLE_SEL_RESET;
			gpio_sel_reg   <= auxseq_pkg::GPIO_SEL_LOOP;
			cell_count_reg <= 4'h0;
			pin_cfg_reg    <= 24'h0;
		end else if (aux_go_in) begin
			mode_reg       <= aux_run_mode_in;
			cell_sel_reg   <= aux_cell_select_in;
			settle_sel_reg <= aux_settle_select_in;
			gpio_sel_reg   <= aux_gpio_select_in;
			cell_count_reg <= active_cell_count_in;
			pin_cfg_reg    <= pin_function_config_in;
		end
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic pin_is_adc(input logic [23:0] cfg,
	                                     input logic [2:0]  idx);
		logic [2:0] f;
		f = cfg[idx*3 +: 3];
		return (f == auxseq_pkg::PIN_ADC) ||
		       (f == auxseq_pkg::PIN_ADC_PROT);
	endfunction

	// Cell channels 1..count are active; count 0 is taken as all 16.
	function automatic logic cell_is_active(input logic [4:0] ch,
	                                         input logic [3:0] cnt);
		logic [4:0] top;
		top = (cnt == 4'h0) ? 5'h10 : {1'b0, cnt};
		return (ch != 5'h00) && (ch <= top);
	endfunction

	// ---------------------------------------------------------------
	// Run state
	// ---------------------------------------------------------------
	auxseq_pkg::auxseq_state_t state_reg;
	logic       running;
	logic       step;
	logic       cycle_end;
	logic [3:0] slot;
	logic       cell_slot;
	logic       gpio_slot;
	logic [3:0] cell_pos;
	logic [3:0] rr_count_reg;
	logic       auto_stop;

	assign running = (state_reg == auxseq_pkg::AUXSEQ_RUN);
	// A slot advances only on a finished conversion while running.
	assign step = running && active_mode_in && conv_done_in;

	assign auto_stop = cycle_end &&
		((mode_reg == auxseq_pkg::MODE_SINGLE) ||
		 (mode_reg == auxseq_pkg::MODE_EIGHT &&
		  rr_count_reg == auxseq_pkg::RR_EIGHT - 4'h1));

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= auxseq_pkg::AUXSEQ_IDLE;
		end else if (aux_go_in) begin
			// Mode 00 with go is the only stop for continuous mode.
			state_reg <= (aux_run_mode_in == auxseq_pkg::MODE_STOP) ?
				auxseq_pkg::AUXSEQ_IDLE : auxseq_pkg::AUXSEQ_RUN;
		end else begin
			unique case (state_reg)
				auxseq_pkg::AUXSEQ_IDLE: begin
					state_reg <= auxseq_pkg::AUXSEQ_IDLE;
				end
				auxseq_pkg::AUXSEQ_RUN: begin
					if (!active_mode_in)
						state_reg <= auxseq_pkg::AUXSEQ_FROZEN;
					else if (auto_stop)
						state_reg <= auxseq_pkg::AUXSEQ_IDLE;
				end
				auxseq_pkg::AUXSEQ_FROZEN: begin
					if (active_mode_in)
						state_reg <= auxseq_pkg::AUXSEQ_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rr_count_reg <= 4'h0;
		end else if (aux_go_in) begin
			rr_count_reg <= 4'h0;
		end else if (cycle_end && rr_count_reg != 4'hf) begin
			rr_count_reg <= rr_count_reg + 4'h1;
		end
	end

	// ---------------------------------------------------------------
	// Slot position
	// ---------------------------------------------------------------
	// Fixed alignment places the cell slot so that it meets main slot
	// 12; dynamic alignment tracks the main converter's target slot.
	assign cell_pos = cell_align_fixed_in ?
		auxseq_pkg::CELL_SLOT :
		((main_cell_slot_in > auxseq_pkg::MAIN_FIXED_SLOT) ?
		  auxseq_pkg::CELL_SLOT :
		  auxseq_pkg::CELL_SLOT - (auxseq_pkg::MAIN_FIXED_SLOT -
		  main_cell_slot_in) % 4'h6);

	auxseq_slot u_slot (
		.clk_sys_in    (clk_sys_in),
		.rst_n_in      (rst_n_in),
		.step_in       (step),
		.clear_in      (aux_go_in),
		.cell_pos_in   (cell_pos),
		.slot_out      (slot),
		.cell_slot_out (cell_slot),
		.gpio_slot_out (gpio_slot),
		.cycle_end_out (cycle_end)
	);

	// ---------------------------------------------------------------
	// GPIO channel
	// ---------------------------------------------------------------
	logic [2:0] gpio_ch_reg;
	logic [7:0] gpio_seen_reg;
	logic       gpio_locked;

	assign gpio_locked = (gpio_sel_reg != auxseq_pkg::GPIO_SEL_LOOP) &&
	                     (gpio_sel_reg <= 4'h8);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gpio_ch_reg <= 3'h0;
		end else if (aux_go_in) begin
			gpio_ch_reg <= (aux_gpio_select_in != 4'h0 &&
			                aux_gpio_select_in <= 4'h8) ?
				3'(aux_gpio_select_in - 4'h1) : 3'h0;
		end else if (step && gpio_slot && !gpio_locked) begin
			gpio_ch_reg <= gpio_ch_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gpio_seen_reg <= 8'h0;
		end else if (aux_go_in) begin
			gpio_seen_reg <= 8'h0;
		end else if (step && gpio_slot) begin
			gpio_seen_reg[gpio_ch_reg] <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Cell multiplexer channel
	// ---------------------------------------------------------------
	logic [4:0] cell_ch_reg;
	logic [4:0] cell_next;
	logic       cell_locked;
	logic       cell_lock_valid;
	logic       settled;
	logic       settle_tick;
	logic       cell_move;
	logic [16:0] cell_seen_reg;
	logic       cell_all_seen;

	assign cell_locked = (cell_sel_reg != auxseq_pkg::CELL_SEL_LOOP);
	assign cell_lock_valid = (cell_sel_reg == auxseq_pkg::CELL_SEL_BB) ||
		cell_is_active(cell_sel_reg, cell_count_reg);

	// Next visited channel in loop mode: active cells then bus-bar.
	always_comb begin
		if (cell_ch_reg == auxseq_pkg::BB_CHANNEL)
			cell_next = 5'h01;
		else if (cell_is_active(cell_ch_reg + 5'h01, cell_count_reg))
			cell_next = cell_ch_reg + 5'h01;
		else
			cell_next = auxseq_pkg::BB_CHANNEL;
	end

	assign cell_move = step && cell_slot && settled && !cell_locked;
	assign settle_tick = running && active_mode_in;

	auxseq_settle u_settle (
		.clk_sys_in  (clk_sys_in),
		.rst_n_in    (rst_n_in),
		.restart_in  (aux_go_in || cell_move),
		.tick_in     (settle_tick),
		.select_in   (settle_sel_reg),
		.limit_a_in  (32'(auxseq_pkg::SETTLE_A_CYC)),
		.limit_b_in  (32'(auxseq_pkg::SETTLE_B_CYC)),
		.limit_c_in  (32'(auxseq_pkg::SETTLE_C_CYC)),
		.settled_out (settled)
	);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_ch_reg <= 5'h01;
		end else if (aux_go_in) begin
			cell_ch_reg <= (aux_cell_select_in == 5'h00) ?
				5'h01 : aux_cell_select_in;
		end else if (cell_move) begin
			cell_ch_reg <= cell_next;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_seen_reg <= 17'h0;
		end else if (aux_go_in) begin
			cell_seen_reg <= 17'h0;
		end else if (step && cell_slot && settled &&
		             cell_ch_reg != 5'h00) begin
			cell_seen_reg[cell_ch_reg - 5'h01] <= 1'b1;
		end
	end

	always_comb begin
		cell_all_seen = 1'b1;
		if (cell_locked) begin
			cell_all_seen = (cell_ch_reg != 5'h00) &&
				cell_seen_reg[cell_ch_reg - 5'h01];
		end else begin
			for (int i = 0; i < 16; i++) begin
				if (cell_is_active(5'(i + 1), cell_count_reg) &&
				    !cell_seen_reg[i])
					cell_all_seen = 1'b0;
			end
			if (!cell_seen_reg[16])
				cell_all_seen = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Misc tracking
	// ---------------------------------------------------------------
	logic [11:0] misc_seen_reg;
	logic        misc_slot;
	logic [3:0]  misc_idx;

	// Misc inputs fill every slot that is neither cell nor GPIO.
	assign misc_slot = !cell_slot && !gpio_slot;
	assign misc_idx = (slot > cell_pos) ? slot - 4'h1 : slot;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			misc_seen_reg <= 12'h0;
		end else if (aux_go_in) begin
			misc_seen_reg <= 12'h0;
		end else if (step && misc_slot &&
		             misc_idx <= auxseq_pkg::MISC_LAST) begin
			misc_seen_reg[misc_idx] <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aux_run_out         <= 1'b0;
			misc_ready_flag_out <= 1'b0;
			cell_ready_flag_out <= 1'b0;
			gpio_ready_flag_out <= 1'b0;
		end else begin
			aux_run_out         <= (state_reg !=
				auxseq_pkg::AUXSEQ_IDLE) && !aux_go_in;
			misc_ready_flag_out <= !aux_go_in && (&misc_seen_reg);
			cell_ready_flag_out <= !aux_go_in && cell_all_seen;
			gpio_ready_flag_out <= !aux_go_in && (&gpio_seen_reg);
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			slot_out         <= 4'h0;
			cell_channel_out <= 5'h01;
			gpio_channel_out <= 3'h0;
			conv_enable_out  <= 1'b0;
		end else begin
			slot_out         <= slot;
			cell_channel_out <= cell_ch_reg;
			gpio_channel_out <= gpio_ch_reg;
			conv_enable_out  <= running && active_mode_in;
		end
	end

	// Results hold the reset pattern unless a valid lock is latched.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gpio_result_high_out <= auxseq_pkg::RESULT_RESET[15:8];
			gpio_result_low_out  <= auxseq_pkg::RESULT_RESET[7:0];
		end else if (aux_go_in) begin
			gpio_result_high_out <= auxseq_pkg::RESULT_RESET[15:8];
			gpio_result_low_out  <= auxseq_pkg::RESULT_RESET[7:0];
		end else if (step && gpio_slot && gpio_locked &&
		             pin_is_adc(pin_cfg_reg, gpio_ch_reg)) begin
			gpio_result_high_out <= conv_data_in[15:8];
			gpio_result_low_out  <= conv_data_in[7:0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_result_out <= auxseq_pkg::RESULT_RESET;
		end else if (aux_go_in) begin
			cell_result_out <= auxseq_pkg::RESULT_RESET;
		end else if (step && cell_slot && settled &&
		             cell_locked && cell_lock_valid) begin
			cell_result_out <= conv_data_in;
		end
	end

	// Protector DAC slots pass the live threshold sample straight out.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			misc_result_out <= 16'h0;
			misc_index_out  <= 4'h0;
			misc_valid_out  <= 1'b0;
		end else begin
			misc_valid_out <= step && misc_slot &&
			                  misc_idx <= auxseq_pkg::MISC_LAST;
			if (step && misc_slot) begin
				misc_index_out  <= misc_idx;
				misc_result_out <= (misc_idx >= 4'h7) ?
					prot_dac_in : conv_data_in;
			end
		end
	end

endmodule // auxseq_top

// ### verif/auxseq_chk.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Port checker for the auxiliary sequencer
// ---------------------------------------------------------------
module auxseq_chk (
	// Clock and reset
	input wire logic        clk_sys_in,
	input wire logic        rst_n_in,
	// Inputs watched
	input wire logic        aux_go_in,
	input wire logic [1:0]  aux_run_mode_in,
	input wire logic        active_mode_in,
	input wire logic        conv_done_in,
	// Outputs watched
	input wire logic [3:0]  slot_out,
	input wire logic        conv_enable_out,
	input wire logic        aux_run_out,
	input wire logic        misc_ready_flag_out,
	input wire logic        cell_ready_flag_out,
	input wire logic        gpio_ready_flag_out,
	input wire logic [3:0]  misc_index_out,
	input wire logic        misc_valid_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	a_go_starts_run: assert property (
		aux_go_in && aux_run_mode_in != auxseq_pkg::MODE_STOP &&
		active_mode_in ##1 active_mode_in |-> ##1 aux_run_out)
		else $error("run status not raised after a start command");
	a_stop_cmd_halts: assert property (
		aux_go_in && aux_run_mode_in == auxseq_pkg::MODE_STOP
		|-> ##2 !aux_run_out)
		else $error("run status still high after a stop command");
	a_go_clears_flags: assert property (
		aux_go_in |-> ##3 !misc_ready_flag_out && !cell_ready_flag_out &&
		!gpio_ready_flag_out)
		else $error("ready flag still set after a start command");
	a_frozen_slot_hold: assert property (
		!active_mode_in && !aux_go_in ##1 !active_mode_in && !aux_go_in
		|=> $stable(slot_out))
		else $error("slot moved while asleep");
	a_frozen_no_conv: assert property (
		!active_mode_in ##1 !active_mode_in |-> !conv_enable_out)
		else $error("converter enabled while asleep");
	a_misc_has_cause: assert property (
		misc_valid_out |-> $past(conv_done_in))
		else $error("misc result without a finished conversion");
	a_misc_index_range: assert property (
		misc_valid_out |-> misc_index_out <= auxseq_pkg::MISC_LAST)
		else $error("misc index outside the twelve inputs");
	a_slot_in_cycle: assert property (
		slot_out <= 4'hd)
		else $error("slot outside the round-robin cycle");
endmodule // auxseq_chk

// ### verif/auxseq_top_tb.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Testbench
// ---------------------------------------------------------------
module auxseq_top_tb;
	logic        clk_sys_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        aux_go_in = 1'b0;
	logic [1:0]  aux_run_mode_in = 2'h0;
	logic [4:0]  aux_cell_select_in = 5'h00;
	logic [3:0]  aux_gpio_select_in = 4'h0;
	logic [23:0] pin_function_config_in = 24'h492492;
	logic        cell_align_fixed_in = 1'b0;
	logic        active_mode_in = 1'b1;
	logic        conv_done_in = 1'b0;
	logic [15:0] conv_data_in = 16'h0000;
	logic [3:0]  slot_out;
	logic [4:0]  cell_channel_out;
	logic [2:0]  gpio_channel_out;
	logic        conv_enable_out;
	logic        aux_run_out;
	logic        misc_ready_flag_out;
	logic        cell_ready_flag_out;
	logic        gpio_ready_flag_out;
	logic [7:0]  gpio_result_high_out;
	logic [7:0]  gpio_result_low_out;
	logic [15:0] cell_result_out;
	logic [15:0] misc_result_out;
	logic [3:0]  misc_index_out;
	logic        misc_valid_out;
	int          err_count = 0;
	int          cmp_count = 0;
	int          misc_cnt = 0;
	logic [3:0]  saved_slot;

	always #2.5 clk_sys_in = ~clk_sys_in;
	// Protector DAC entries must carry the live threshold sample.
	always @(posedge clk_sys_in) begin
		if (misc_valid_out === 1'b1) begin
			misc_cnt++;
			if (misc_index_out >= 4'h7)
				chk("misc_dac", 16'h0a5a, misc_result_out);
		end
	end

	auxseq_top i_auxseq_top (
		.clk_sys_in            (clk_sys_in),
		.rst_n_in              (rst_n_in),
		.aux_go_in             (aux_go_in),
		.aux_run_mode_in       (aux_run_mode_in),
		.aux_cell_select_in    (aux_cell_select_in),
		.aux_settle_select_in  (2'h0),
		.aux_gpio_select_in    (aux_gpio_select_in),
		.active_cell_count_in  (4'h0),
		.pin_function_config_in(pin_function_config_in),
		.cell_align_fixed_in   (cell_align_fixed_in),
		.active_mode_in        (active_mode_in),
		.main_cell_slot_in     (4'h8),
		.conv_done_in          (conv_done_in),
		.conv_data_in          (conv_data_in),
		.prot_dac_in           (16'h0a5a),
		.slot_out              (slot_out),
		.cell_channel_out      (cell_channel_out),
		.gpio_channel_out      (gpio_channel_out),
		.conv_enable_out       (conv_enable_out),
		.aux_run_out           (aux_run_out),
		.misc_ready_flag_out   (misc_ready_flag_out),
		.cell_ready_flag_out   (cell_ready_flag_out),
		.gpio_ready_flag_out   (gpio_ready_flag_out),
		.gpio_result_high_out  (gpio_result_high_out),
		.gpio_result_low_out   (gpio_result_low_out),
		.cell_result_out       (cell_result_out),
		.misc_result_out       (misc_result_out),
		.misc_index_out        (misc_index_out),
		.misc_valid_out        (misc_valid_out)
	);

	// ---------------------------------------------------------------
	// Access tasks
	// ---------------------------------------------------------------
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp,
			input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic go(input logic [1:0] mode, input logic [3:0] gsel);
		aux_run_mode_in = mode;
		aux_gpio_select_in = gsel;
		aux_go_in = 1'b1;
		@(posedge clk_sys_in);
		#1;
		aux_go_in = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask

	// The GPIO slot carries its own channel so a locked result names it.
	task automatic pulse();
		if (slot_out === 4'hd)
			conv_data_in = {8'ha0, 5'h00, gpio_channel_out};
		else
			conv_data_in = 16'h0100 + {12'h000, slot_out};
		conv_done_in = 1'b1;
		@(posedge clk_sys_in);
		#1;
		conv_done_in = 1'b0;
		@(posedge clk_sys_in);
		#1;
	endtask

	task automatic run(input int ncyc, input bit chk_ch);
		int gcnt;
		for (int c = 0; c < ncyc; c++) begin
			gcnt = 0;
			for (int s = 0; s < 14; s++) begin
				if (slot_out === 4'hd) begin
					gcnt++;
					if (chk_ch)
						chk("gpio_channel", 16'(c % 8), 16'(gpio_channel_out));
				end
				pulse();
			end
			chk("gpio_slots", 16'h0001, 16'(gcnt));
		end
	endtask

	task automatic wait_run(input logic v);
		for (int i = 0; i < 20 && aux_run_out !== v; i++)
			@(posedge clk_sys_in);
		#1;
		if (aux_run_out !== v) begin
			err_count++;
			$display("wrong value aux_run expected %h seen %h", v, aux_run_out);
			results();
		end
	endtask

	task automatic chk_res(input logic [15:0] exp);
		chk("gpio_result", exp, {gpio_result_high_out, gpio_result_low_out});
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_sys_in);
		#1;
		rst_n_in = 1'b1;
		chk_res(auxseq_pkg::RESULT_RESET);
		chk("cell_result", 16'h8000, cell_result_out);
		chk("run", 16'h0000, 16'(aux_run_out));
		// Single cycle; mode and GPIO select changes after go stay unused.
		go(auxseq_pkg::MODE_SINGLE, 4'h0);
		aux_run_mode_in = auxseq_pkg::MODE_CONT;
		aux_gpio_select_in = 4'h3;
		chk("run", 16'h0001, 16'(aux_run_out));
		misc_cnt = 0;
		run(1, 1'b1);
		wait_run(1'b0);
		chk("misc_count", 16'h000c, 16'(misc_cnt));
		chk_res(16'h8000);
		chk("misc_ready", 16'h0001, 16'(misc_ready_flag_out));
		chk("gpio_ready", 16'h0000, 16'(gpio_ready_flag_out));
		chk("cell_result", 16'h8000, cell_result_out);
		// Eight cycles looping over every GPIO.
		go(auxseq_pkg::MODE_EIGHT, 4'h0);
		chk("misc_ready", 16'h0000, 16'(misc_ready_flag_out));
		run(8, 1'b1);
		wait_run(1'b0);
		chk("gpio_ready", 16'h0001, 16'(gpio_ready_flag_out));
		chk_res(16'h8000);
		// Locked GPIO3, active then inactive.
		go(auxseq_pkg::MODE_EIGHT, 4'h3);
		run(8, 1'b0);
		wait_run(1'b0);
		chk_res(16'ha002);
		pin_function_config_in[8:6] = 3'h0;
		go(auxseq_pkg::MODE_EIGHT, 4'h3);
		run(8, 1'b0);
		wait_run(1'b0);
		chk_res(16'h8000);
		// Continuous run with a sleep in the middle, then a stop.
		cell_align_fixed_in = 1'b1;
		aux_cell_select_in = auxseq_pkg::CELL_SEL_BB;
		go(auxseq_pkg::MODE_CONT, 4'h0);
		run(9, 1'b0);
		chk("run", 16'h0001, 16'(aux_run_out));
		chk("cell_channel", 16'h0011, 16'(cell_channel_out));
		chk("cell_ready", 16'h0000, 16'(cell_ready_flag_out));
		chk("cell_result", 16'h8000, cell_result_out);
		pulse();
		saved_slot = slot_out;
		active_mode_in = 1'b0;
		repeat (2) pulse();
		chk("frozen_slot", 16'(saved_slot), 16'(slot_out));
		chk("frozen_enable", 16'h0000, 16'(conv_enable_out));
		active_mode_in = 1'b1;
		repeat (2) @(posedge clk_sys_in);
		#1;
		pulse();
		chk("resumed_slot", (saved_slot == 4'hd) ? 16'h0000 :
			16'(saved_slot) + 16'h0001, 16'(slot_out));
		go(auxseq_pkg::MODE_STOP, 4'h0);
		wait_run(1'b0);
		chk("cell_result", 16'h8000, cell_result_out);
		results();
	end
endmodule // auxseq_top_tb

bind auxseq_top auxseq_chk i_auxseq_chk (
	.clk_sys_in         (clk_sys_in),
	.rst_n_in           (rst_n_in),
	.aux_go_in          (aux_go_in),
	.aux_run_mode_in    (aux_run_mode_in),
	.active_mode_in     (active_mode_in),
	.conv_done_in       (conv_done_in),
	.slot_out           (slot_out),
	.conv_enable_out    (conv_enable_out),
	.aux_run_out        (aux_run_out),
	.misc_ready_flag_out(misc_ready_flag_out),
	.cell_ready_flag_out(cell_ready_flag_out),
	.gpio_ready_flag_out(gpio_ready_flag_out),
	.misc_index_out     (misc_index_out),
	.misc_valid_out     (misc_valid_out)
);
